// *** rtl/sar_link_pkg.sv ***
package sar_link_pkg;
    localparam int unsigned result_width = 18;
    localparam int unsigned frame_clocks = 19;
    localparam logic [17:0] code_pos_full = 18'h1FFFF;
    localparam logic [17:0] code_zero = 18'h00000;
    localparam logic [17:0] code_neg_step = 18'h3FFFF;
    localparam logic [17:0] code_neg_full = 18'h20000;
    localparam int unsigned clk_period_ns = 10;
    localparam int unsigned trigger_high_ns = 81;
    localparam int unsigned trigger_high_cycles =
        (trigger_high_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int unsigned trigger_drop_ns = 50;
    localparam int unsigned trigger_drop_cycles =
        (trigger_drop_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int unsigned trigger_to_clock_guard_ns = 100;
    localparam int unsigned trigger_to_clock_guard_cycles =
        (trigger_to_clock_guard_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int unsigned bit_clock_half_cycles = 4;
    localparam int unsigned inter_conversion_interval_cycles = 8;
    localparam int unsigned max_rate_hz = 222000;
    localparam int unsigned clocks_per_second = 1000000000 / clk_period_ns;
    localparam int unsigned min_frame_cycles =
        (clocks_per_second + max_rate_hz - 1) / max_rate_hz;
endpackage

// *** rtl/sar_link_if.sv ***
`timescale 1ns/1ns
interface sar_link_if;
    logic trigger;
    logic bit_clock_input;
    logic data_left;
    logic data_right;
    modport converter (input trigger, input bit_clock_input, output data_left, output data_right);
    modport controller (output trigger, output bit_clock_input, input data_left, input data_right);
endinterface

// *** rtl/sar_converter_end.sv ***
`timescale 1ns/1ns
module sar_converter_end
    import sar_link_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link
    sar_link_if.converter link,
    // analog comparator stand-ins
    input wire logic comp_left,
    input wire logic comp_right,
    // status
    output logic tracking,
    output logic hold_strobe,
    output logic [result_width-1:0] trim_correction_dac_left,
    output logic [result_width-1:0] trim_correction_dac_right,
    output logic [result_width-1:0] capacitor_array_dac_left,
    output logic [result_width-1:0] capacitor_array_dac_right
);
    typedef struct packed {
        logic trig_d;
        logic clk_d;
        logic [frame_clocks-1:0] seq;
        logic [result_width-1:0] left;
        logic [result_width-1:0] right;
        logic out_l;
        logic out_r;
        logic hold;
        logic busy;
    } state_t;
    state_t cur;
    state_t next_s;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        logic rise;
        rise = 1'b0;
        next_s = cur;
        next_s.hold = 1'b0;
        next_s.trig_d = link.trigger;
        next_s.clk_d = link.bit_clock_input;
        rise = link.bit_clock_input && !cur.clk_d;
        if (link.trigger && !cur.trig_d) begin
            // MSB switched in, all others off, both channels held together
            next_s.busy = 1'b1;
            next_s.hold = 1'b1;
            next_s.seq = {{(frame_clocks-1){1'b0}}, 1'b1};
            next_s.left = {1'b1, {(result_width-1){1'b0}}};
            next_s.right = {1'b1, {(result_width-1){1'b0}}};
        end else if (rise && cur.busy) begin
            for (int i = 0; i < result_width; i++) begin
                if (cur.seq[i]) begin
                    // msb of offset code is inverted to two's complement at the pin
                    next_s.left[result_width-1-i] = comp_left;
                    next_s.right[result_width-1-i] = comp_right;
                    next_s.out_l = (i == 0) ? !comp_left : comp_left;
                    next_s.out_r = (i == 0) ? !comp_right : comp_right;
                    if (i + 1 < result_width) begin
                        next_s.left[result_width-2-i] = 1'b1;
                        next_s.right[result_width-2-i] = 1'b1;
                    end
                end
            end
            next_s.seq = {cur.seq[frame_clocks-2:0], 1'b0};
            if (cur.seq[frame_clocks-1]) begin
                next_s.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.data_left = cur.out_l;
    assign link.data_right = cur.out_r;
    assign tracking = !cur.busy;
    assign hold_strobe = cur.hold;
    assign capacitor_array_dac_left = cur.left;
    assign capacitor_array_dac_right = cur.right;
    assign trim_correction_dac_left = cur.left;
    assign trim_correction_dac_right = cur.right;
endmodule

// *** rtl/sar_controller_end.sv ***
`timescale 1ns/1ns
module sar_controller_end
    import sar_link_pkg::*;
#(
    parameter int unsigned half_cycles = bit_clock_half_cycles,
    parameter int unsigned gap_cycles = inter_conversion_interval_cycles
)
(
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link
    sar_link_if.controller link,
    // user
    input wire logic start,
    output logic busy,
    output logic result_valid,
    output logic [result_width-1:0] result_left,
    output logic [result_width-1:0] result_right
);
    typedef enum logic [2:0] {idle, trig_hi, guard, clk_lo, clk_hi, gap} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [15:0] cnt;
        logic [15:0] since;
        logic [4:0] edges;
        logic trig;
        logic bclk;
        logic [result_width-1:0] sl;
        logic [result_width-1:0] sr;
        logic valid;
    } state_t;
    state_t cur;
    state_t next_s;

    // ****************************************
    // sequence
    // ****************************************
    always_comb begin
        next_s = cur;
        next_s.valid = 1'b0;
        next_s.cnt = cur.cnt + 16'h0001;
        // cycles since the last trigger was launched
        next_s.since = cur.since + 16'h0001;
        unique case (cur.phase)
            idle: begin
                next_s.cnt = '0;
                if (start) begin
                    next_s.phase = trig_hi;
                    next_s.trig = 1'b1;
                    next_s.edges = '0;
                    next_s.since = '0;
                end
            end
            trig_hi: if (cur.cnt == 16'(trigger_high_cycles - 1)) begin
                next_s.trig = 1'b0;
                next_s.phase = guard;
                next_s.cnt = '0;
            end
            guard: if (cur.cnt == 16'(trigger_to_clock_guard_cycles)) begin
                next_s.phase = clk_lo;
                next_s.cnt = '0;
            end
            clk_lo: if (cur.cnt == 16'(half_cycles - 1)) begin
                next_s.bclk = 1'b1;
                next_s.phase = clk_hi;
                next_s.cnt = '0;
                next_s.edges = cur.edges + 5'h01;
                // sample on rise: bit n decided at edge n appears after edge n, taken at edge n+1
                if (cur.edges >= 5'h01) begin
                    next_s.sl = {cur.sl[result_width-2:0], link.data_left};
                    next_s.sr = {cur.sr[result_width-2:0], link.data_right};
                end
            end
            clk_hi: if (cur.cnt == 16'(half_cycles - 1)) begin
                next_s.bclk = 1'b0;
                next_s.cnt = '0;
                if (cur.edges == 5'(frame_clocks)) begin
                    next_s.phase = gap;
                    next_s.valid = 1'b1;
                end else begin
                    next_s.phase = clk_lo;
                end
            end
            // hold off the next trigger so the rate never exceeds the maximum
            gap: if (cur.cnt >= 16'(gap_cycles) &&
                    cur.since >= 16'(min_frame_cycles - 1)) begin
                next_s.phase = idle;
            end
            default: next_s.phase = idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_s;
        end
    end

    assign link.trigger = cur.trig;
    assign link.bit_clock_input = cur.bclk;
    assign busy = cur.phase != idle;
    assign result_valid = cur.valid;
    assign result_left = cur.sl;
    assign result_right = cur.sr;
endmodule

// *** verification/sar_link_properties.sv ***
`timescale 1ns/1ns
module sar_link_properties
    import sar_link_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic trigger,
    input wire logic bit_clock_input,
    input wire logic data_left,
    input wire logic data_right
);
    logic prev;
    logic [4:0] cnt;
    logic trig_d;
    logic [4:0] hi_cnt;
    logic [15:0] span;
    // rises of the bit clock since the last trigger
    always_ff @(posedge clk) begin
        prev <= bit_clock_input;
        if (rst || trigger) begin
            cnt <= 5'h00;
        end else if (bit_clock_input && !prev) begin
            cnt <= cnt + 5'h01;
        end
    end
    // cycles the trigger has stood high, and cycles since its last rise
    always_ff @(posedge clk) begin
        trig_d <= trigger;
        if (rst || !trigger) begin
            hi_cnt <= 5'h00;
        end else begin
            hi_cnt <= hi_cnt + 5'h01;
        end
        if (rst) begin
            span <= 16'hFFFF;
        end else if (trigger && !trig_d) begin
            span <= 16'h0001;
        end else if (span != 16'hFFFF) begin
            span <= span + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence trig_pulse;
        ##9 (!trigger && hi_cnt == 5'(trigger_high_cycles));
    endsequence
    sequence quiet_guard;
        !bit_clock_input [*8];
    endsequence
    AST_TRIG_WIDTH: assert property ($rose(trigger) |-> trig_pulse)
        else $error("trigger pulse width wrong");
    AST_GUARD: assert property ($rose(trigger) |-> trig_pulse ##0 quiet_guard)
        else $error("bit clock inside guard");
    AST_TRIG_LOW: assert property ($rose(bit_clock_input) |-> !trigger && !$past(trigger, 5))
        else $error("trigger high near clock rise");
    AST_CLK_HIGH: assert property ($rose(bit_clock_input) |-> bit_clock_input [*4] ##1 !bit_clock_input)
        else $error("bit clock high phase wrong");
    AST_LEFT_TIME: assert property ($changed(data_left) |-> $past(bit_clock_input) && !$past(bit_clock_input, 2))
        else $error("left data moved off clock rise");
    AST_RIGHT_TIME: assert property ($changed(data_right) |-> $past(bit_clock_input) && !$past(bit_clock_input, 2))
        else $error("right data moved off clock rise");
    AST_FRAME: assert property ($rose(trigger) |-> ##[150:220] (cnt == 5'h13))
        else $error("frame lacks 19 clocks");
    AST_LOCKOUT: assert property ((cnt == 5'h13 && $past(cnt) == 5'h13 && !trigger) |-> $stable(data_left) && $stable(data_right))
        else $error("data moved after frame end");
    AST_RATE: assert property ($rose(trigger) |-> span >= 16'(min_frame_cycles))
        else $error("triggers closer than the fastest rate");
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
    import sar_link_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic comp_left = 1'b0;
    logic comp_right = 1'b0;
    logic [1:0] pat_l = 2'h0;
    logic [1:0] pat_r = 2'h0;
    logic tracking, hold_strobe, busy, result_valid, prev_clk, prev_trig;
    logic [result_width-1:0] trim_l, trim_r, cap_l, cap_r, res_l, res_r, wire_l, wire_r;
    int rises = 0, falls = 0, holds = 0, err_count = 0, compares = 0;
    sar_link_if link ();
    sar_converter_end sar_converter_end_inst (.clk(clk), .rst(rst), .ce(ce), .link(link),
        .comp_left(comp_left), .comp_right(comp_right), .tracking(tracking),
        .hold_strobe(hold_strobe), .trim_correction_dac_left(trim_l),
        .trim_correction_dac_right(trim_r), .capacitor_array_dac_left(cap_l),
        .capacitor_array_dac_right(cap_r));
    sar_controller_end sar_controller_end_inst (.clk(clk), .rst(rst), .ce(ce), .link(link),
        .start(start), .busy(busy), .result_valid(result_valid), .result_left(res_l),
        .result_right(res_r));
    sar_link_properties sar_link_properties_inst (.clk(clk), .rst(rst), .trigger(link.trigger),
        .bit_clock_input(link.bit_clock_input), .data_left(link.data_left),
        .data_right(link.data_right));
    initial forever #5 clk = ~clk;
    // ****
    // wire watcher and comparator stand-in: msb decision, then the rest
    // ****
    always @(negedge clk) begin
        if (hold_strobe === 1'b1) holds = holds + 1;
        if (link.trigger === 1'b1 && prev_trig !== 1'b1) begin
            rises = 0;
            falls = 0;
        end
        if (link.bit_clock_input === 1'b1 && prev_clk !== 1'b1) begin
            rises = rises + 1;
            if (rises > 1 && rises < 20) begin
                wire_l = {wire_l[16:0], link.data_left};
                wire_r = {wire_r[16:0], link.data_right};
            end
        end
        if (link.bit_clock_input === 1'b0 && prev_clk === 1'b1) falls = falls + 1;
        comp_left = (falls == 0) ? pat_l[1] : pat_l[0];
        comp_right = (falls == 0) ? pat_r[1] : pat_r[0];
        prev_clk = link.bit_clock_input;
        prev_trig = link.trigger;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic run_frame(input logic [1:0] pl, pr, input logic [17:0] el, er);
        int n;
        pat_l = pl;
        pat_r = pr;
        holds = 0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (result_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= 400) begin
            err_count = err_count + 1;
            finish_test();
        end
        check(res_l, el);
        check(res_r, er);
        check(wire_l, el);
        check(wire_r, er);
        check(trim_l, {~el[17], el[16:0]});
        check(trim_r, {~er[17], er[16:0]});
        check(cap_l, {~el[17], el[16:0]});
        check(cap_r, {~er[17], er[16:0]});
        check({17'h00000, tracking}, 18'h00001);
        check(holds[17:0], 18'h00001);
        n = 0;
        while (busy !== 1'b0 && n < 600) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= 600) begin
            err_count = err_count + 1;
            finish_test();
        end
        @(negedge clk);
    endtask
    task automatic test_codes;
        run_frame(2'h3, 2'h0, code_pos_full, code_neg_full);
        run_frame(2'h2, 2'h1, code_zero, code_neg_step);
        $display("codes test done");
    endtask
    task automatic test_long_gap;
        repeat (3000) @(negedge clk);
        run_frame(2'h1, 2'h2, code_neg_step, code_zero);
        $display("long gap test done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        test_codes();
        test_long_gap();
        finish_test();
    end
endmodule
